// [core/slave_wd_map.svh]
// Purpose: register offsets, reset values and timing for the supervision block
// Assumes: 16-bit register port, byte offsets as the register map prints them
// Notes:   definitions only
`ifndef SLAVE_WD_MAP_SVH
`define SLAVE_WD_MAP_SVH
`define WD_MULT_OFS      16'h0400
`define WD_LPI_OFS       16'h0410
`define WD_CHAN_OFS      16'h0420
`define WD_STATE_OFS     16'h0130
`define WD_STATUS_OFS    16'h0134
`define WD_MULT_RST      16'h09c2
`define WD_LPI_RST       16'h03e8
`define WD_CHAN_RST      16'h03e8
`define WD_BASE_EXTRA    16'h0002
`define WD_BASE_TICK_NS  40
`define WD_CLK_MHZ       25
`endif

// [core/slave_wd_pkg.sv]
// Purpose: types shared by the supervision block
// Assumes: nothing
// Notes:   state request codes follow the slave state machine numbering
package slave_wd_pkg;
  typedef enum logic [2:0]
  {
    ST_INIT,
    ST_PREOP,
    ST_SAFEOP,
    ST_RUN,
    ST_BOOT
  } sm_state_t;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic mbx_ok;
    logic pd_ok;
    logic dc_ok;
    logic inputs_copied;
  } check_t;

  typedef struct packed
  {
    logic mbx_en;
    logic file_only;
    logic pd_en;
    logic inputs_en;
  } gate_t;
endpackage

// [core/slave_watchdog_state_machine.sv]
// Purpose: two watchdogs and the slave state machine of a fieldbus slave
// Assumes: register port and events come from logic on clk_sys_i
// Notes:   outputs are registered and zero in reset; safe value applies on either trip or in any state but run
//
// Function
// [R1] restart channel watchdog on process data exchange
// [R2] channel watchdog trip leaves state unchanged
// [R3] trip holds until next process data access
// [R4] trip forces outputs to configurable safe value
// [R5] local interface watchdog trips on silence
// [R6] shared multiplier register at 0x0400
// [R7] per-watchdog counts at 0x0410, 0x0420
// [R8] tick lasts multiplier plus two base ticks
// [R9] defaults 2498 and 1000 give 100 ms
// [R10] channel count zero disables that watchdog
// [R11] master writes only selected watchdog settings
// [R12] start in init, no mailbox or data
// [R13] master sets channels 0 and 1 in init
// [R14] init to preop checks mailbox setup
// [R15] preop allows mailbox, blocks process data
// [R16] safeop entry checks setup, copies inputs first
// [R17] safeop: traffic on, inputs update, outputs safe
// [R18] master sends valid outputs before run
// [R19] run state applies master outputs
// [R20] boot only from init, file mailbox only
// [R21] startup normally ends in run state
// [R22] failed check refuses and keeps state
`timescale 1ns/100ps
`default_nettype none
`include "slave_wd_map.svh"
module slave_watchdog_state_machine
#(
  parameter int OUT_W = 8
)
(
  input  wire logic               clk_sys_i,
  input  wire logic               arst_n_i,
  input  wire slave_wd_pkg::reg_req_t reg_req_i,
  output logic [15:0]             reg_rdata_o,
  input  wire logic               pd_done_i,
  input  wire logic               lpi_access_i,
  input  wire logic               lpi_wd_en_i,
  input  wire logic [2:0]         state_req_i,
  input  wire logic               state_req_vld_i,
  input  wire slave_wd_pkg::check_t check_i,
  input  wire logic [OUT_W-1:0]   out_data_i,
  input  wire logic [OUT_W-1:0]   safe_value_i,
  output logic [OUT_W-1:0]        out_pins_o,
  output slave_wd_pkg::gate_t     gate_o,
  output logic [2:0]              state_o,
  output logic                    chan_trip_o,
  output logic                    lpi_trip_o,
  output logic                    req_refused_o
);
  import slave_wd_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  localparam int BASE_NS = 1000 / `WD_CLK_MHZ;
  if (OUT_W < 1 || BASE_NS != `WD_BASE_TICK_NS)
  begin : g_bad_param
    $error("unsupported parameter set");
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] mult_reg, mult_next;
  logic [15:0] lpi_cnt_reg, lpi_cnt_next;
  logic [15:0] chan_cnt_reg, chan_cnt_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        chan_trip_reg, lpi_trip_reg;
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction
  sm_state_t state_reg, state_next;
  logic      refused_reg, refused_next;
  always_comb
  begin
    mult_next     = mult_reg;
    lpi_cnt_next  = lpi_cnt_reg;
    chan_cnt_next = chan_cnt_reg;
    rdata_next    = rdata_reg;
    if (reg_req_i.wr)
    begin
      if (hit(reg_req_i.addr, `WD_MULT_OFS))
        mult_next = reg_req_i.wdata; // R6
      if (hit(reg_req_i.addr, `WD_LPI_OFS))
        lpi_cnt_next = reg_req_i.wdata; // R7
      if (hit(reg_req_i.addr, `WD_CHAN_OFS))
        chan_cnt_next = reg_req_i.wdata; // R7
    end
    if (reg_req_i.rd)
    begin
      if (hit(reg_req_i.addr, `WD_MULT_OFS))
        rdata_next = mult_reg;
      else if (hit(reg_req_i.addr, `WD_LPI_OFS))
        rdata_next = lpi_cnt_reg;
      else if (hit(reg_req_i.addr, `WD_CHAN_OFS))
        rdata_next = chan_cnt_reg;
      else if (hit(reg_req_i.addr, `WD_STATE_OFS))
        rdata_next = {13'h0000, state_reg};
      else if (hit(reg_req_i.addr, `WD_STATUS_OFS))
        rdata_next = {13'h0000, refused_reg, lpi_trip_reg, chan_trip_reg};
      else
        rdata_next = 16'h0000;
    end
  end

  // unwritten registers keep their values
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mult_reg     <= `WD_MULT_RST; // R9
      lpi_cnt_reg  <= `WD_LPI_RST;
      chan_cnt_reg <= `WD_CHAN_RST; // R9
      rdata_reg    <= 16'h0000;
    end
    else
    begin
      mult_reg     <= mult_next; // R11
      lpi_cnt_reg  <= lpi_cnt_next;
      chan_cnt_reg <= chan_cnt_next;
      rdata_reg    <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared tick: multiplier plus two base cycles
  logic [16:0] base_reg, base_next;
  logic        tick;
  assign tick = (base_reg >= ({1'b0, mult_reg} + 17'h00001)); // R8
  always_comb
  begin
    base_next = tick ? 17'h00000 : base_reg + 17'h00001; // R8
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      base_reg <= 17'h00000;
    else
      base_reg <= base_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // watchdog counters
  logic [15:0] chan_tk_reg, chan_tk_next, lpi_tk_reg, lpi_tk_next;
  logic        chan_trip_next, lpi_trip_next;
  always_comb
  begin
    chan_tk_next   = chan_tk_reg;
    chan_trip_next = chan_trip_reg;
    if (pd_done_i)
    begin
      chan_tk_next   = 16'h0000; // R1
      chan_trip_next = 1'b0; // R3
    end
    else if (chan_cnt_reg == 16'h0000)
      chan_trip_next = chan_trip_reg; // R10
    else if (tick && !chan_trip_reg)
    begin
      if (chan_tk_reg + 16'h0001 >= chan_cnt_reg)
        chan_trip_next = 1'b1; // R7
      else
        chan_tk_next = chan_tk_reg + 16'h0001;
    end
    lpi_tk_next   = lpi_tk_reg;
    lpi_trip_next = lpi_trip_reg;
    if (lpi_access_i || !lpi_wd_en_i || lpi_cnt_reg == 16'h0000)
    begin
      lpi_tk_next   = 16'h0000;
      lpi_trip_next = 1'b0;
    end
    else if (tick && !lpi_trip_reg)
    begin
      if (lpi_tk_reg + 16'h0001 >= lpi_cnt_reg)
        lpi_trip_next = 1'b1; // R5
      else
        lpi_tk_next = lpi_tk_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      chan_tk_reg   <= 16'h0000;
      chan_trip_reg <= 1'b0;
      lpi_tk_reg    <= 16'h0000;
      lpi_trip_reg  <= 1'b0;
    end
    else
    begin
      chan_tk_reg   <= chan_tk_next;
      chan_trip_reg <= chan_trip_next;
      lpi_tk_reg    <= lpi_tk_next;
      lpi_trip_reg  <= lpi_trip_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave state machine
  always_comb
  begin
    state_next   = state_reg; // R2
    refused_next = refused_reg;
    if (state_req_vld_i)
    begin
      refused_next = 1'b1; // R22
      case (state_req_i)
        3'h1:
        begin
          if (state_reg != ST_BOOT && (state_reg != ST_INIT || check_i.mbx_ok))
          begin
            state_next   = ST_PREOP; // R14
            refused_next = 1'b0;
          end
        end
        3'h2:
        begin
          if (state_reg == ST_RUN || (state_reg == ST_PREOP && check_i.pd_ok
              && check_i.dc_ok && check_i.inputs_copied))
          begin
            state_next   = ST_SAFEOP; // R16
            refused_next = 1'b0;
          end
        end
        3'h3:
        begin
          if (state_reg == ST_SAFEOP || state_reg == ST_RUN)
          begin
            state_next   = ST_RUN; // R21
            refused_next = 1'b0;
          end
        end
        3'h4:
        begin
          if (state_reg == ST_INIT || state_reg == ST_BOOT)
          begin
            state_next   = ST_BOOT; // R20
            refused_next = 1'b0;
          end
        end
        3'h0:
        begin
          state_next   = ST_INIT;
          refused_next = 1'b0;
        end
        default:
          refused_next = 1'b1;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg   <= ST_INIT; // R12
      refused_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      refused_reg <= refused_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs and traffic gates
  logic [OUT_W-1:0] out_reg, out_next;
  gate_t            gate_reg, gate_next;
  always_comb
  begin
    gate_next.mbx_en    = (state_reg != ST_INIT); // R12
    gate_next.file_only = (state_reg == ST_BOOT); // R20
    gate_next.pd_en     = (state_reg == ST_SAFEOP || state_reg == ST_RUN); // R15
    gate_next.inputs_en = gate_next.pd_en; // R17
    if (state_reg == ST_RUN && !chan_trip_reg && !lpi_trip_reg)
      out_next = out_data_i; // R19
    else
      out_next = safe_value_i; // R4
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      out_reg  <= '0;
      gate_reg <= '0;
    end
    else
    begin
      out_reg  <= out_next;
      gate_reg <= gate_next;
    end
  end
  assign reg_rdata_o   = rdata_reg;
  assign out_pins_o    = out_reg;
  assign gate_o        = gate_reg;
  assign state_o       = state_reg;
  assign chan_trip_o   = chan_trip_reg;
  assign lpi_trip_o    = lpi_trip_reg;
  assign req_refused_o = refused_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_trip_seen;
    !chan_trip_reg && !state_req_vld_i ##1 chan_trip_reg;
  endsequence
  a_chan_restart: assert property (pd_done_i // R1
    |=> chan_tk_reg == 16'h0000 && !chan_trip_reg)
    else $error("channel watchdog not restarted");
  a_state_kept: assert property (s_trip_seen |-> $stable(state_reg)) // R2
    else $error("state moved on trip");
  a_trip_sticky: assert property (chan_trip_reg && !pd_done_i // R3
    |=> chan_trip_reg)
    else $error("trip cleared without access");
  a_safe_out: assert property (chan_trip_reg // R4
    |=> out_pins_o == $past(safe_value_i))
    else $error("outputs not safe on trip");
  a_zero_off: assert property (chan_cnt_reg == 16'h0000 // R10
    && !chan_trip_reg && !pd_done_i |=> !chan_trip_reg)
    else $error("disabled watchdog tripped");
  a_tick_len: assert property (tick && $stable(mult_reg) // R8
    |-> $past(base_reg) == {1'b0, mult_reg})
    else $error("tick length wrong");
  a_boot_entry: assert property ($rose(state_reg == ST_BOOT) // R20
    |-> $past(state_reg) == ST_INIT)
    else $error("boot entered from wrong state");
  a_no_pd_early: assert property (state_reg == ST_PREOP // R15
    |=> !gate_o.pd_en)
    else $error("process data open in preop");
  a_refuse_hold: assert property (state_req_vld_i // R22
    && state_req_i == 3'h2 && state_reg == ST_PREOP
    && !(check_i.pd_ok && check_i.dc_ok && check_i.inputs_copied)
    |=> state_reg == ST_PREOP && req_refused_o)
    else $error("failed check not refused");
endmodule
`default_nettype wire

// [dv/master_model.sv]
// Purpose: fieldbus master model, state requests and data exchange
// Assumes: all requests launched at a rising edge
// Notes:   behavioural; sends outputs with each exchange, does not set up mailbox channels
`timescale 1ns/100ps
`default_nettype none
module master_model
(
  input  wire logic       clk_sys_i,
  output logic [2:0]      state_req_o,
  output logic            state_req_vld_o,
  output logic            pd_done_o,
  output logic [7:0]      out_data_o
);
  import slave_wd_pkg::*;
  initial
  begin
    state_req_o = 3'h0;
    state_req_vld_o = 1'b0;
    pd_done_o = 1'b0;
    out_data_o = 8'h00;
  end
  // one-cycle request; mailbox channels taken as set up in init
  task automatic request(input sm_state_t s);
    @(posedge clk_sys_i);
    state_req_o <= s;
    state_req_vld_o <= 1'b1;
    @(posedge clk_sys_i);
    state_req_vld_o <= 1'b0;
  endtask
  // output data travels with the exchange, before any run request
  task automatic exchange(input logic [7:0] d);
    @(posedge clk_sys_i);
    out_data_o <= d;
    pd_done_o <= 1'b1;
    @(posedge clk_sys_i);
    pd_done_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/slave_watchdog_state_machine_test.sv]
// Purpose: self-checking bench for watchdogs and state machine
// Assumes: 25 MHz clock, reset held 4 cycles
// Notes:   watchdog ticks shortened through the multiplier register
`timescale 1ns/100ps
`default_nettype none
`include "slave_wd_map.svh"
module slave_watchdog_state_machine_test;
  import slave_wd_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  reg_req_t    req = '0;
  logic [15:0] rdata;
  logic        lpi_acc = 1'b0;
  logic        lpi_en = 1'b0;
  check_t      chk_in = '0;
  logic [7:0]  safe_val = 8'h5a;
  logic [7:0]  out_pins;
  logic [7:0]  out_data;
  gate_t       gate;
  logic [2:0]  state;
  logic [2:0]  req_st;
  logic        vld;
  logic        pd_done;
  logic        c_trip;
  logic        l_trip;
  logic        refused;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          n;
  always #20 clk = ~clk;
  master_model i_master
  (
    .clk_sys_i       (clk),
    .state_req_o     (req_st),
    .state_req_vld_o (vld),
    .pd_done_o       (pd_done),
    .out_data_o      (out_data)
  );
  slave_watchdog_state_machine #(.OUT_W(8)) i_dut
  (
    .clk_sys_i       (clk),
    .arst_n_i        (arst_n),
    .reg_req_i       (req),
    .reg_rdata_o     (rdata),
    .pd_done_i       (pd_done),
    .lpi_access_i    (lpi_acc),
    .lpi_wd_en_i     (lpi_en),
    .state_req_i     (req_st),
    .state_req_vld_i (vld),
    .check_i         (chk_in),
    .out_data_i      (out_data),
    .safe_value_i    (safe_val),
    .out_pins_o      (out_pins),
    .gate_o          (gate),
    .state_o         (state),
    .chan_trip_o     (c_trip),
    .lpi_trip_o      (l_trip),
    .req_refused_o   (refused)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] e,
                        input string nm);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    cmp(nm, e, rdata);
  endtask
  // request a state, then check state, refusal and gates once settled
  task automatic go(input sm_state_t s, input logic rf,
                    input sm_state_t e, input logic [1:0] mp);
    i_master.request(s);
    @(posedge clk);
    @(negedge clk);
    cmp("state", {13'h0, e}, {13'h0, state});
    cmp("refused", {15'h0, rf}, {15'h0, refused});
    cmp("mbx_pd_gate", {14'h0, mp}, {14'h0, gate.mbx_en, gate.pd_en});
  endtask
  task automatic wait_trip(input bit lpi);
    n = 0;
    while (((lpi ? l_trip : c_trip) !== 1'b1) && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      error_cnt++;
      $display("unexpected trip expected 1 seen 0");
      close_out();
    end
    // eight ticks of three cycles each with multiplier 1
    cmp("trip_time", 16'h1, {15'h0, (n >= 21 && n <= 27)});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(`WD_MULT_OFS, `WD_MULT_RST, "multiplier");
    reg_rd(`WD_CHAN_OFS, `WD_CHAN_RST, "chan_count");
    reg_rd(`WD_LPI_OFS, `WD_LPI_RST, "lpi_count");
    reg_rd(16'h0500, 16'h0000, "unmapped");
    cmp("state", {13'h0, ST_INIT}, {13'h0, state});
    cmp("init_gate", 16'h0, {14'h0, gate.mbx_en, gate.pd_en});
    $display("test registers done");
    go(ST_PREOP, 1'b1, ST_INIT, 2'b00);
    @(posedge clk);
    chk_in <= '{mbx_ok: 1'b1, pd_ok: 1'b1, dc_ok: 1'b1, inputs_copied: 1'b0};
    go(ST_PREOP, 1'b0, ST_PREOP, 2'b10);
    go(ST_BOOT, 1'b1, ST_PREOP, 2'b10);
    go(ST_SAFEOP, 1'b1, ST_PREOP, 2'b10);
    @(posedge clk);
    chk_in.inputs_copied <= 1'b1;
    go(ST_SAFEOP, 1'b0, ST_SAFEOP, 2'b11);
    i_master.exchange(8'h3c);
    repeat (2) @(negedge clk);
    cmp("safeop_out", {8'h0, safe_val}, {8'h0, out_pins});
    go(ST_RUN, 1'b0, ST_RUN, 2'b11);
    cmp("run_out", 16'h003c, {8'h0, out_pins});
    cmp("run_inputs", 16'h1, {15'h0, gate.inputs_en});
    $display("test states done");
    reg_wr(`WD_MULT_OFS, 16'h0001);
    reg_rd(`WD_MULT_OFS, 16'h0001, "multiplier_wr");
    reg_wr(`WD_CHAN_OFS, 16'h0008);
    i_master.exchange(8'h3c);
    wait_trip(1'b0);
    cmp("trip_state", {13'h0, ST_RUN}, {13'h0, state});
    repeat (2) @(negedge clk);
    cmp("trip_out", {8'h0, safe_val}, {8'h0, out_pins});
    reg_rd(`WD_STATUS_OFS, 16'h0001, "status");
    reg_rd(`WD_STATE_OFS, {13'h0, ST_RUN}, "state_reg");
    reg_wr(`WD_LPI_OFS, 16'h0010);
    repeat (30) @(negedge clk);
    cmp("trip_held", 16'h1, {15'h0, c_trip});
    i_master.exchange(8'h3c);
    repeat (2) @(negedge clk);
    cmp("trip_clear", 16'h0, {15'h0, c_trip});
    cmp("clear_out", 16'h003c, {8'h0, out_pins});
    reg_wr(`WD_CHAN_OFS, 16'h0000);
    repeat (60) @(negedge clk);
    cmp("chan_off", 16'h0, {15'h0, c_trip});
    $display("test channel watchdog done");
    reg_wr(`WD_LPI_OFS, 16'h0008);
    @(posedge clk);
    lpi_en <= 1'b1;
    lpi_acc <= 1'b1;
    @(posedge clk);
    lpi_acc <= 1'b0;
    wait_trip(1'b1);
    go(ST_INIT, 1'b0, ST_INIT, 2'b00);
    go(ST_BOOT, 1'b0, ST_BOOT, 2'b10);
    cmp("boot_file", 16'h1, {15'h0, gate.file_only});
    cmp("boot_inputs", 16'h0, {15'h0, gate.inputs_en});
    $display("test local watchdog and boot done");
    close_out();
  end
endmodule
`default_nettype wire
